// ---- src/tic_pkg.sv ----
// Package for the time interval counter: register map, field layout, resets, timing.
// Assumes a classic Wishbone slave with 32-bit data and an 8-bit register in each word.
package tic_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] TIC_ADR_CTRL = 8'h00;
  localparam logic [7:0] TIC_ADR_INTERVAL_LENGTH_VALUE = 8'h04;
  localparam logic [7:0] TIC_ADR_FRAC = 8'h08;
  localparam logic [7:0] TIC_ADR_SEC = 8'h0C;
  localparam logic [7:0] TIC_ADR_MIN = 8'h10;
  localparam logic [7:0] TIC_ADR_HOUR = 8'h14;
  localparam logic [7:0] TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO = 8'h18;
  localparam logic [7:0] TIC_ADR_IVEC = 8'h1C;
  localparam logic [7:0] TIC_ADR_ISTAT = 8'h20;
  localparam logic [7:0] TIC_ADR_IMASK = 8'h24;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TIC_CTL_CLKDIS = 0;
  localparam int TIC_CTL_IEN = 1;
  localparam int TIC_CTL_FLAG = 2;
  localparam int TIC_CTL_SINGLE = 3;
  localparam int TIC_CTL_TB_LO = 4;
  localparam int TIC_CTL_H24 = 6;
  localparam int TIC_IE_EN = 2;
  localparam int TIC_IE_PRI = 6;
  localparam int TIC_EV_INTERVAL = 0;
  localparam int TIC_EV_SECOND = 1;
  localparam int TIC_EV_HOUR_WRAP = 2;

  // ****************************************************************
  // Reset values, wraps and vector
  // ****************************************************************
  localparam logic [7:0] TIC_CTRL_RST = 8'h00;
  localparam logic [7:0] TIC_BYTE_ZERO = 8'h00;
  localparam logic [7:0] TIC_FRAC_WRAP = 8'h7F;
  localparam logic [7:0] TIC_SM_WRAP = 8'h3B;
  localparam logic [7:0] TIC_H24_WRAP = 8'h17;
  localparam logic [7:0] TIC_H255_WRAP = 8'hFE;
  localparam logic [7:0] TIC_VECTOR = 8'h53;
  localparam logic [7:0] TIC_RANK = 8'h0B;
  localparam logic [2:0] TIC_EV_ALL = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int TIC_CLK_HZ = 25000000;
  localparam int TIC_TICK_HZ = 128;
  localparam int TIC_TICK_CYC = TIC_CLK_HZ / TIC_TICK_HZ;

  // Interval timebase codes
  typedef enum logic [1:0] {
    TIC_TB_FRAC,
    TIC_TB_SEC,
    TIC_TB_MIN,
    TIC_TB_HOUR
  } tic_tb_t;

  // Wishbone request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tic_wb_req_t;

  // Rollover strobes of the elapsed-time chain
  typedef struct packed {
    logic frac;
    logic sec;
    logic min;
    logic hour;
  } tic_roll_t;

endpackage : tic_pkg

// ---- src/tic_tick_gen.sv ----
// Tick generator: one-cycle pulse at 128 Hz from the system clock.
// Assumes clk_i at the package rate; counting freezes with ce_i low and clears to zero with run_i low.
`timescale 1ns/100ps
module tic_tick_gen
  import tic_pkg::*;
#(
  parameter int DIV = TIC_TICK_CYC
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic run_i, // Time clock running
  output logic tick_o // One 128th second elapsed
);

  // Elaboration check on the divider
  if (DIV < 2 || DIV > 16777215) begin : g_bad_div
    $error("tic_tick_gen: DIV out of range");
  end

  localparam logic [23:0] LAST = 24'(DIV - 1);

  logic [23:0] cnt_r;

  // Divider counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 24'h000000;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (!run_i) begin
        cnt_r <= 24'h000000;
      end else if (cnt_r == LAST) begin
        cnt_r <= 24'h000000;
        tick_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 24'h000001;
      end
    end
  end

endmodule : tic_tick_gen

// ---- src/tic_counter.sv ----
// Time interval counter: elapsed-time clock, programmable interval, interrupt logic.
// Assumes a classic Wishbone master on one clock; registers are 8 bits in 32-bit words.
//
// Functional notes
// - A two-bit timebase field picks the interval unit of 1/128 s, seconds, minutes or hours.
// - With the single-interval bit clear the interval reloads and restarts, else it runs once.
// - The interval-elapsed flag in the control register sets when the interval completes.
// - Clearing the interval enable stops and clears the interval count; setting it runs it.
// - The elapsed-time clock runs while the clock disable bit is zero and stops when it is one.
// - The hour-format bit picks a 24-hour wrap when set and a 255-hour wrap when clear.
// - Software reads elapsed 128ths, seconds, minutes and hours registers.
// - The interval flag reaches the interrupt request only while its enable bit is set.
// - A priority bit places the interval interrupt at the high level.
// - The interval interrupt vectors to 53h and ranks eleventh within its level.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/100ps
module tic_counter
  import tic_pkg::*;
#(
  parameter int TICK_DIV = TIC_TICK_CYC
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic irq_req_o, // Interval interrupt request
  output logic irq_high_o, // Request is high priority
  output logic [7:0] irq_vector_o, // Vector address
  output logic irq_o // Status interrupt level
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  if (TICK_DIV < 2) begin : g_bad_div
    $error("tic_counter: TICK_DIV too small");
  end

  tic_wb_req_t req;
  tic_roll_t roll;
  logic [7:0] ctrl_r;
  logic [7:0] interval_length_value_r;
  logic [7:0] frac_r;
  logic [7:0] sec_r;
  logic [7:0] min_r;
  logic [7:0] hour_r;
  logic [7:0] interrupt_enable_priority_two_r;
  logic [7:0] icnt_r;
  logic [7:0] icnt_nxt;
  logic [2:0] istat_r;
  logic [2:0] imask_r;
  logic [7:0] rd_byte;
  logic tick;
  logic unit_tick;
  logic int_done;
  logic wr_en;
  logic rd_en;
  logic [7:0] hour_wrap;
  tic_tb_t tb;

  // Byte-lane zero write helper
  function automatic logic [7:0] lane0(input logic [7:0] old, input tic_wb_req_t r);
    lane0 = r.sel[0] ? r.dat[7:0] : old;
  endfunction : lane0

  // Roll-over counter step
  function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] wrap);
    step = (v == wrap) ? TIC_BYTE_ZERO : v + 8'h01;
  endfunction : step

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};
  assign wr_en = ce_i && req.cyc && req.stb && req.we && !wb_ack_o;
  assign rd_en = ce_i && req.cyc && req.stb && !req.we && !wb_ack_o;
  assign tb = tic_tb_t'(ctrl_r[TIC_CTL_TB_LO +: 2]);

  // Acknowledge one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_byte = TIC_BYTE_ZERO;
    case (req.adr)
      TIC_ADR_CTRL: rd_byte = ctrl_r;
      TIC_ADR_INTERVAL_LENGTH_VALUE: rd_byte = interval_length_value_r;
      TIC_ADR_FRAC: rd_byte = frac_r;
      TIC_ADR_SEC: rd_byte = sec_r;
      TIC_ADR_MIN: rd_byte = min_r;
      TIC_ADR_HOUR: rd_byte = hour_r;
      TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO: rd_byte = interrupt_enable_priority_two_r;
      TIC_ADR_IVEC: rd_byte = TIC_VECTOR;
      TIC_ADR_ISTAT: rd_byte = {5'h00, istat_r};
      TIC_ADR_IMASK: rd_byte = {5'h00, imask_r};
      default: rd_byte = TIC_BYTE_ZERO;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_en) begin
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  // ****************************************************************
  // Elapsed-time clock
  // ****************************************************************
  tic_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(!ctrl_r[TIC_CTL_CLKDIS]),
    .tick_o(tick)
  );

  assign hour_wrap = ctrl_r[TIC_CTL_H24] ? TIC_H24_WRAP : TIC_H255_WRAP;
  assign roll.frac = tick && (frac_r == TIC_FRAC_WRAP);
  assign roll.sec = roll.frac && (sec_r == TIC_SM_WRAP);
  assign roll.min = roll.sec && (min_r == TIC_SM_WRAP);
  assign roll.hour = roll.min && (hour_r == hour_wrap);

  // Fraction, seconds, minutes and hours chain; software writes preset them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frac_r <= TIC_BYTE_ZERO;
      sec_r <= TIC_BYTE_ZERO;
      min_r <= TIC_BYTE_ZERO;
      hour_r <= TIC_BYTE_ZERO;
    end else if (ce_i) begin
      if (tick) begin
        frac_r <= step(frac_r, TIC_FRAC_WRAP);
      end
      if (roll.frac) begin
        sec_r <= step(sec_r, TIC_SM_WRAP);
      end
      if (roll.sec) begin
        min_r <= step(min_r, TIC_SM_WRAP);
      end
      if (roll.min) begin
        hour_r <= (hour_r >= hour_wrap) ? TIC_BYTE_ZERO : hour_r + 8'h01;
      end
      if (wr_en && req.adr == TIC_ADR_FRAC) begin
        frac_r <= lane0(frac_r, req) & TIC_FRAC_WRAP;
      end
      if (wr_en && req.adr == TIC_ADR_SEC) begin
        sec_r <= lane0(sec_r, req);
      end
      if (wr_en && req.adr == TIC_ADR_MIN) begin
        min_r <= lane0(min_r, req);
      end
      if (wr_en && req.adr == TIC_ADR_HOUR) begin
        hour_r <= lane0(hour_r, req);
      end
    end
  end

  // ****************************************************************
  // Interval counter
  // ****************************************************************
  // Unit tick of the selected timebase
  always_comb begin
    case (tb)
      TIC_TB_FRAC: unit_tick = tick;
      TIC_TB_SEC: unit_tick = roll.frac;
      TIC_TB_MIN: unit_tick = roll.sec;
      TIC_TB_HOUR: unit_tick = roll.min;
      default: unit_tick = 1'b0;
    endcase
  end

  assign int_done = ctrl_r[TIC_CTL_IEN] && unit_tick && (icnt_nxt == interval_length_value_r);

  // Next interval count
  always_comb begin
    icnt_nxt = icnt_r + 8'h01;
  end

  // Interval count: cleared when disabled, restarted on match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icnt_r <= TIC_BYTE_ZERO;
    end else if (ce_i) begin
      if (!ctrl_r[TIC_CTL_IEN]) begin
        icnt_r <= TIC_BYTE_ZERO;
      end else if (int_done) begin
        icnt_r <= TIC_BYTE_ZERO;
      end else if (unit_tick) begin
        icnt_r <= icnt_nxt;
      end
    end
  end

  // Control register; hardware flag set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= TIC_CTRL_RST;
    end else if (ce_i) begin
      if (wr_en && req.adr == TIC_ADR_CTRL) begin
        ctrl_r <= lane0(ctrl_r, req) & 8'h7F;
      end
      if (int_done) begin
        ctrl_r[TIC_CTL_FLAG] <= 1'b1;
        if (ctrl_r[TIC_CTL_SINGLE]) begin
          ctrl_r[TIC_CTL_IEN] <= 1'b0;
        end
      end
    end
  end

  // Interval length and enable/priority registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interval_length_value_r <= TIC_BYTE_ZERO;
      interrupt_enable_priority_two_r <= TIC_BYTE_ZERO;
    end else if (wr_en) begin
      if (req.adr == TIC_ADR_INTERVAL_LENGTH_VALUE) begin
        interval_length_value_r <= lane0(interval_length_value_r, req);
      end
      if (req.adr == TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO) begin
        interrupt_enable_priority_two_r <= lane0(interrupt_enable_priority_two_r, req) & 8'h77;
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_req_o = ctrl_r[TIC_CTL_FLAG] && interrupt_enable_priority_two_r[TIC_IE_EN];
  assign irq_high_o = irq_req_o && interrupt_enable_priority_two_r[TIC_IE_PRI];
  assign irq_vector_o = TIC_VECTOR;
  assign irq_o = |(istat_r & imask_r);

  // Sticky status cleared by its read, new events win; mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_r <= 3'h0;
      imask_r <= 3'h0;
    end else if (ce_i) begin
      if (rd_en && req.adr == TIC_ADR_ISTAT) begin
        istat_r <= 3'h0;
      end
      if (int_done) begin
        istat_r[TIC_EV_INTERVAL] <= 1'b1;
      end
      if (roll.frac) begin
        istat_r[TIC_EV_SECOND] <= 1'b1;
      end
      if (roll.hour) begin
        istat_r[TIC_EV_HOUR_WRAP] <= 1'b1;
      end
      if (wr_en && req.adr == TIC_ADR_IMASK) begin
        imask_r <= (req.sel[0] ? req.dat[2:0] : imask_r) & TIC_EV_ALL;
      end
    end
  end

endmodule : tic_counter

// ---- bench/tic_counter_asserts.sv ----
// Checker for the time interval counter: bus handshake, read ranges, interrupt outputs.
// Assumes it is bound to tic_counter and sees only that module's ports.
`timescale 1ns/100ps
module tic_counter_asserts
  import tic_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic ce_i, // Enable
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Selects
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic irq_req_o, // Interval request
  input wire logic irq_high_o, // High priority
  input wire logic [7:0] irq_vector_o, // Vector
  input wire logic irq_o // Status level
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken, and a read answered from one address
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_rd(logic [7:0] a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  property p_ack; s_take |=> wb_ack_o; endproperty
  property p_pulse; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
  property p_idle; !wb_stb_i && ce_i |=> !wb_ack_o; endproperty
  property p_vec; irq_vector_o == TIC_VECTOR; endproperty
  property p_high; irq_high_o |-> irq_req_o; endproperty
  property p_en;
    wb_ack_o && wb_we_i && wb_adr_i == TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO && wb_sel_i[0] && !wb_dat_i[TIC_IE_EN]
      |-> !irq_req_o;
  endproperty
  property p_frac; s_rd(TIC_ADR_FRAC) |-> wb_dat_o[31:7] == 25'h0; endproperty
  property p_sec; s_rd(TIC_ADR_SEC) |-> wb_dat_o <= 32'h3B; endproperty
  property p_min; s_rd(TIC_ADR_MIN) |-> wb_dat_o <= 32'h3B; endproperty
  property p_hour; s_rd(TIC_ADR_HOUR) |-> wb_dat_o <= 32'hFE; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_pulse: assert property (p_pulse) else $error("ack longer than a cycle");
  a_idle: assert property (p_idle) else $error("ack without request");
  a_vec: assert property (p_vec) else $error("wrong vector");
  a_high: assert property (p_high) else $error("priority without request");
  a_en: assert property (p_en) else $error("request while disabled");
  a_frac: assert property (p_frac) else $error("fraction out of range");
  a_sec: assert property (p_sec) else $error("seconds out of range");
  a_min: assert property (p_min) else $error("minutes out of range");
  a_hour: assert property (p_hour) else $error("hours out of range");
endmodule : tic_counter_asserts

bind tic_counter tic_counter_asserts tic_counter_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_req_o(irq_req_o), .irq_high_o(irq_high_o),
  .irq_vector_o(irq_vector_o), .irq_o(irq_o));

// ---- bench/tic_counter_tb.sv ----
// Testbench for the time interval counter: registers, elapsed clock, intervals, interrupts.
// Assumes the tick divider is cut to 4 cycles, so one second lasts 512 clock cycles.
`timescale 1ns/100ps
module tic_counter_tb;
  import tic_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, irq_req_o, irq_high_o, irq_o;
  logic [7:0] irq_vector_o;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  int t0;
  // ****************************************************************
  // Clock, design and timeout
  // ****************************************************************
  always #20 clk_i = ~clk_i;
  tic_counter #(.TICK_DIV(4)) tic_counter_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_req_o(irq_req_o), .irq_high_o(irq_high_o), .irq_vector_o(irq_vector_o),
    .irq_o(irq_o));
  // Cut a hang short
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task test_done();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(n, e, q);
  endtask : rc
  task wait_irq();
    do @(posedge clk_i); while (irq_req_o !== 1'b1);
  endtask : wait_irq
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(TIC_ADR_CTRL, 32'h0, "ctrl_rst");
    rc(TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO, 32'h0, "interrupt_enable_priority_two_rst");
    rc(TIC_ADR_IVEC, 32'h53, "vector");
    rc(8'h28, 32'h0, "unmapped");
    wr(TIC_ADR_CTRL, 32'h01);
    xfer(1'b0, TIC_ADR_FRAC, 32'h0, 4'hF);
    repeat (200) @(posedge clk_i);
    rc(TIC_ADR_FRAC, q, "frac_stopped");
    for (int i = 0; i < 4; i++) begin
      wr(TIC_ADR_CTRL, 32'hC9 | (i << 4));
      rc(TIC_ADR_CTRL, 32'h49 | (i << 4), "ctrl_fields");
    end
    wr(TIC_ADR_IMASK, 32'h02);
    wr(TIC_ADR_CTRL, 32'h40);
    repeat (1030) @(posedge clk_i);
    rc(TIC_ADR_SEC, 32'h2, "seconds");
    xfer(1'b0, TIC_ADR_FRAC, 32'h0, 4'hF);
    chk("frac_range", 32'h0, q & 32'hFFFFFF80);
    chk("irq_level", 32'h1, {31'h0, irq_o});
    rc(TIC_ADR_ISTAT, 32'h2, "status");
    @(posedge clk_i);
    chk("irq_cleared", 32'h0, {31'h0, irq_o});
    wr(TIC_ADR_INTERVAL_LENGTH_VALUE, 32'h5);
    wr(TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO, 32'h44);
    rc(TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO, 32'h44, "interrupt_enable_priority_two");
    wr(TIC_ADR_CTRL, 32'h42);
    wait_irq();
    t0 = cyc_n;
    chk("irq_high", 32'h1, {31'h0, irq_high_o});
    rc(TIC_ADR_CTRL, 32'h46, "flag_reload");
    wr(TIC_ADR_CTRL, 32'h42);
    wait_irq();
    chk("interval_cycles", 32'd20, cyc_n - t0);
    xfer(1'b0, TIC_ADR_ISTAT, 32'h0, 4'hF);
    chk("status_interval", 32'h1, q & 32'h1);
    wr(TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO, 32'h40);
    @(posedge clk_i);
    chk("req_masked", 32'h0, {31'h0, irq_req_o});
    wr(TIC_ADR_INTERRUPT_ENABLE_PRIORITY_TWO, 32'h04);
    @(posedge clk_i);
    chk("req_low_pri", 32'h2, {30'h0, irq_req_o, irq_high_o});
    wr(TIC_ADR_CTRL, 32'h40);
    repeat (100) @(posedge clk_i);
    rc(TIC_ADR_CTRL, 32'h40, "interval_off");
    wr(TIC_ADR_INTERVAL_LENGTH_VALUE, 32'h1);
    wr(TIC_ADR_CTRL, 32'h5A);
    wait_irq();
    rc(TIC_ADR_CTRL, 32'h5C, "single_shot");
    xfer(1'b1, TIC_ADR_INTERVAL_LENGTH_VALUE, 32'h33, 4'hE);
    rc(TIC_ADR_INTERVAL_LENGTH_VALUE, 32'h1, "no_select");
    rc(TIC_ADR_MIN, 32'h0, "minutes");
    rc(TIC_ADR_HOUR, 32'h0, "hours");
    test_done();
  end
endmodule : tic_counter_tb
